// [common/wdopt_pkg.sv]
package wdopt_pkg;
    // Register map: service port shares the reset-vector low byte location
    localparam logic [15:0] WDOPT_SERVICE_ADDR = 16'hFFFF;
    localparam logic [15:0] WDOPT_OPT2_ADDR    = 16'h001E;
    localparam logic [15:0] WDOPT_OPT1_ADDR    = 16'h001F;
    localparam logic [7:0]  WDOPT_OPT_RESET    = 8'h00;
    localparam logic [7:0]  WDOPT_RDATA_IDLE   = 8'h00;

    // Option register 2 field positions
    localparam int WDOPT_OSC_STOP_BIT   = 1;
    localparam int WDOPT_SERIAL_SRC_BIT = 0;
    localparam int WDOPT_OPT2_USED      = 2;

    // Option register 1 field positions
    localparam int WDOPT_RATE_BIT      = 7;
    localparam int WDOPT_MON_STOP_BIT  = 6;
    localparam int WDOPT_MON_RSTD_BIT  = 5;
    localparam int WDOPT_MON_PWRD_BIT  = 4;
    localparam int WDOPT_RANGE_BIT     = 3;
    localparam int WDOPT_SHORT_REC_BIT = 2;
    localparam int WDOPT_STOP_OK_BIT   = 1;
    localparam int WDOPT_WDT_DIS_BIT   = 0;

    // Counter structure
    localparam int WDOPT_PRESC_W   = 12;
    localparam int WDOPT_MAIN_W    = 6;
    localparam int WDOPT_FAST_TAP  = 7;
    localparam int WDOPT_KEEP_LOW  = 4;
    localparam logic [11:0] WDOPT_EARLY = 12'h010;

    // Timing counts in crystal clock cycles (clk period 25 ns)
    localparam int WDOPT_CLK_PERIOD_NS = 25;
    localparam int WDOPT_FAST_TIMEOUT  = 8176;
    localparam int WDOPT_SLOW_TIMEOUT  = 262128;
    localparam logic [5:0]  WDOPT_RST_PULSE_CYC = 6'h20;
    localparam logic [12:0] WDOPT_SHORT_REC_CYC = 13'h0020;
    localparam logic [12:0] WDOPT_LONG_REC_CYC  = 13'h1000;
    localparam logic [12:0] WDOPT_POR_CLR_CYC   = 13'h1000;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } wdopt_bus_t;

    typedef struct packed {
        logic oscInStop;
        logic serialClkSel;
        logic monInStop;
        logic monResetDisable;
        logic monPowerDown;
        logic supplyFiveVolt;
    } wdopt_opts_t;

    typedef enum logic [1:0] {WDOPT_RUN, WDOPT_STOP, WDOPT_RECOVER} wdopt_state_t;
endpackage

// [design/wdopt_core.sv]
`timescale 1ns/1ps
module wdopt_core
    import wdopt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        porN,
    input  wire wdopt_bus_t  bus,
    output logic [7:0]       rdata,
    input  wire logic [7:0]  resetVecLow,
    input  wire logic        vectorFetch,
    input  wire logic        stopReq,
    input  wire logic        wakeIrq,
    input  wire logic        wakeRstPin,
    input  wire logic        monitorEnter,
    input  wire logic        breakActive,
    input  wire logic        vtstIrqPin,
    input  wire logic        vtstRstPin,
    output logic             rstPinOut,
    output logic             rstPinOe,
    output logic             wdtCause,
    output logic             illegalStopRst,
    output logic             stopMode,
    output logic             stopExit,
    output wdopt_opts_t      opts
);

    // Position within one prescaler period for the selected rate
    function automatic logic [11:0] periodPos(input logic [11:0] p, input logic fast);
        periodPos = fast ? {5'h00, p[WDOPT_FAST_TAP-1:0]} : p;
    endfunction

    function automatic logic [11:0] periodLast(input logic fast);
        periodLast = fast ? 12'h07F : 12'hFFF;
    endfunction

    logic [1:0]           porSync;
    logic [1:0]           vIrqSync;
    logic [1:0]           vRstSync;
    logic [11:0]          presc;
    logic [5:0]           mainCnt;
    logic [5:0]           pulseCnt;
    logic [12:0]          porCnt;
    logic [12:0]          recCnt;
    logic [7:0]           opt1;
    logic [7:0]           opt2;
    logic                 rangeBit;
    logic                 written1;
    logic                 written2;
    logic                 rangeWritten;
    logic                 monIrqHold;
    logic                 monBlank;
    wdopt_state_t         state;
    wdopt_state_t         next_state;
    logic [11:0]          next_presc;
    logic [5:0]           next_main;
    logic [12:0]          next_rec;
    logic [7:0]           opt1Read;

    // Pins from outside the clock domain pass two flops first
    always_ff @(posedge clk) begin
        porSync  <= {porSync[0], porN};
        vIrqSync <= {vIrqSync[0], vtstIrqPin};
        vRstSync <= {vRstSync[0], vtstRstPin};
    end

    wire porActive = ~porSync[1];
    wire vIrq      = vIrqSync[1];
    wire vRst      = vRstSync[1];
    wire intRst    = ~nrst | porActive;

    // Address decode shared by writes and reads
    wire hitSvc  = bus.addr == WDOPT_SERVICE_ADDR;
    wire hitOpt1 = bus.addr == WDOPT_OPT1_ADDR;
    wire hitOpt2 = bus.addr == WDOPT_OPT2_ADDR;
    wire service = bus.wr & hitSvc;
    wire wrOpt1  = bus.wr & hitOpt1;
    wire wrOpt2  = bus.wr & hitOpt2;

    // Run condition; wait mode has no input here, so the count goes on through it
    wire fastRate   = opt1[WDOPT_RATE_BIT];
    wire stopOk     = opt1[WDOPT_STOP_OK_BIT];
    wire shortRec   = opt1[WDOPT_SHORT_REC_BIT];
    wire breakHold  = breakActive & vRst;
    wire stopGo     = (state == WDOPT_RUN) & stopReq & stopOk;
    wire wdtRun     = ~opt1[WDOPT_WDT_DIS_BIT] & ~monIrqHold & ~monBlank & ~breakHold
                      & (state == WDOPT_RUN) & ~stopGo & ~intRst;
    wire porClrFire = porCnt == 13'h0001;

    // Tick at the end of each prescaler period; overflow lands a fixed lead before rollover
    wire [11:0] pos  = periodPos(presc, fastRate);
    wire tick        = wdtRun & (pos == periodLast(fastRate));
    wire overflow    = wdtRun & ~service & (mainCnt == 6'h3F)
                       & (pos == periodLast(fastRate) - WDOPT_EARLY);
    wire prescClear  = intRst | porClrFire | vectorFetch | (state != WDOPT_RUN) | stopGo;

    // Prescaler: service clears all but the low four stages, so the period phase restarts within 16 cycles
    always_comb begin
        if (prescClear) begin
            next_presc = '0;
        end else if (service) begin
            next_presc = {{(WDOPT_PRESC_W-WDOPT_KEEP_LOW){1'b0}}, presc[WDOPT_KEEP_LOW-1:0]};
        end else if (wdtRun) begin
            next_presc = presc + 12'h001;
        end else begin
            next_presc = presc;
        end
    end

    assign next_main = (intRst | service) ? 6'h00 : (tick ? mainCnt + 6'h01 : mainCnt);

    always_ff @(posedge clk) begin
        presc   <= next_presc;
        mainCnt <= next_main;
    end

    // Reset pulse survives the system reset it causes; only power-on cuts it
    always_ff @(posedge clk) begin
        if (porActive) begin
            pulseCnt <= 6'h00;
            wdtCause <= 1'b0;
        end else begin
            pulseCnt <= overflow ? WDOPT_RST_PULSE_CYC : (pulseCnt != 6'h00 ? pulseCnt - 6'h01 : 6'h00);
            wdtCause <= overflow;
        end
    end

    // Open-drain reset pin only ever pulls low; no interrupt path exists
    assign rstPinOut = 1'b0;
    assign rstPinOe  = pulseCnt != 6'h00;

    // Power-on delay counter for the late prescaler clear
    always_ff @(posedge clk) begin
        if (porActive) begin
            porCnt <= WDOPT_POR_CLR_CYC;
        end else if (porCnt != 13'h0000) begin
            porCnt <= porCnt - 13'h0001;
        end
    end

    // Monitor holds: set wins over the release in the same cycle
    always_ff @(posedge clk) begin
        if (porActive) begin
            monIrqHold <= 1'b0;
            monBlank   <= 1'b0;
        end else begin
            monIrqHold <= (monitorEnter & vIrq) | (monIrqHold & (vIrq | vRst));
            monBlank   <= (monitorEnter & ~vIrq) | monBlank;
        end
    end

    // Option latches: one write per reset, the range bit is re-armed only at power-on
    always_ff @(posedge clk) begin
        if (intRst) begin
            opt1     <= WDOPT_OPT_RESET;
            opt2     <= WDOPT_OPT_RESET;
            written1 <= 1'b0;
            written2 <= 1'b0;
        end else begin
            if (wrOpt1 & ~written1) begin
                opt1     <= bus.wdata;
                written1 <= 1'b1;
            end
            if (wrOpt2 & ~written2) begin
                opt2     <= {{(8-WDOPT_OPT2_USED){1'b0}}, bus.wdata[WDOPT_OPT2_USED-1:0]};
                written2 <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (porActive) begin
            rangeBit     <= 1'b0;
            rangeWritten <= 1'b0;
        end else if (wrOpt1 & ~rangeWritten) begin
            rangeBit     <= bus.wdata[WDOPT_RANGE_BIT];
            rangeWritten <= 1'b1;
        end
    end

    // Range bit readback comes from its own latch, not the shared register
    always_comb begin
        opt1Read                  = opt1;
        opt1Read[WDOPT_RANGE_BIT] = rangeBit;
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst || !bus.rd) begin
            rdata <= WDOPT_RDATA_IDLE;
        end else if (hitSvc) begin
            rdata <= resetVecLow;
        end else if (hitOpt1) begin
            rdata <= opt1Read;
        end else if (hitOpt2) begin
            rdata <= opt2;
        end else begin
            rdata <= WDOPT_RDATA_IDLE;
        end
    end

    // Option outputs to oscillator, serial and low-voltage monitor
    assign opts.oscInStop       = opt2[WDOPT_OSC_STOP_BIT];
    assign opts.serialClkSel    = opt2[WDOPT_SERIAL_SRC_BIT];
    assign opts.monInStop       = opt1[WDOPT_MON_STOP_BIT] & ~opt1[WDOPT_MON_PWRD_BIT];
    assign opts.monResetDisable = opt1[WDOPT_MON_RSTD_BIT];
    assign opts.monPowerDown    = opt1[WDOPT_MON_PWRD_BIT];
    assign opts.supplyFiveVolt  = rangeBit;

    // Stop sequencer; a reset-pin wake forces the long delay regardless of the option
    always_comb begin
        next_state = state;
        next_rec   = recCnt;
        case (state)
            WDOPT_RUN: begin
                if (stopGo) begin
                    next_state = WDOPT_STOP;
                end
            end
            WDOPT_STOP: begin
                if (wakeRstPin) begin
                    next_state = WDOPT_RECOVER;
                    next_rec   = WDOPT_LONG_REC_CYC;
                end else if (wakeIrq) begin
                    next_state = WDOPT_RECOVER;
                    next_rec   = shortRec ? WDOPT_SHORT_REC_CYC : WDOPT_LONG_REC_CYC;
                end
            end
            WDOPT_RECOVER: begin
                next_rec = recCnt - 13'h0001;
                if (recCnt == 13'h0001) begin
                    next_state = WDOPT_RUN;
                end
            end
            default: begin
                next_state = WDOPT_RUN;
            end
        endcase
    end

    // Stop state is kept across ordinary resets so a reset-pin wake finishes its delay
    always_ff @(posedge clk) begin
        if (porActive) begin
            state          <= WDOPT_RUN;
            recCnt         <= 13'h0000;
            stopExit       <= 1'b0;
            illegalStopRst <= 1'b0;
        end else begin
            state          <= next_state;
            recCnt         <= next_rec;
            stopExit       <= (state == WDOPT_RECOVER) & (recCnt == 13'h0001);
            illegalStopRst <= (state == WDOPT_RUN) & stopReq & ~stopOk;
        end
    end

    assign stopMode = state != WDOPT_RUN;

    // Helper: cycles since a phase-aligned service, valid while counting uninterrupted
    logic [18:0] sinceSvc;
    logic        exact;
    always_ff @(posedge clk) begin
        if (intRst) begin
            sinceSvc <= '0;
            exact    <= 1'b0;
        end else if (service) begin
            sinceSvc <= '0;
            exact    <= presc[WDOPT_KEEP_LOW-1:0] == '0;
        end else begin
            sinceSvc <= sinceSvc + 19'h00001;
            exact    <= exact & wdtRun & ~prescClear;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_wake_short;
        (state == WDOPT_STOP) && wakeIrq && !wakeRstPin && shortRec;
    endsequence

    sequence s_wake_pin;
        (state == WDOPT_STOP) && wakeRstPin;
    endsequence

    a_timeout_count: assert property (overflow && exact |->
        sinceSvc == (fastRate ? 19'(WDOPT_FAST_TIMEOUT - 1) : 19'(WDOPT_SLOW_TIMEOUT - 1)))
        else $error("watchdog timeout length wrong");
    a_pulse_width: assert property (overflow && pulseCnt == 6'h00 |=>
        rstPinOe ##31 rstPinOe ##1 !rstPinOe)
        else $error("reset pulse not 32 cycles");
    a_cause_flag: assert property (overflow |=> wdtCause ##1 !wdtCause)
        else $error("cause flag not a single pulse");
    a_service_clear: assert property (service && !tick |=> mainCnt == 6'h00 && presc[11:4] == 8'h00)
        else $error("service did not clear counters");
    a_vector_read: assert property (bus.rd && hitSvc |=> rdata == $past(resetVecLow))
        else $error("service read not reset vector");
    a_option_once: assert property (wrOpt1 && written1 |=> opt1 == $past(opt1))
        else $error("option written twice");
    a_stop_freeze: assert property (stopMode ##1 stopMode |-> $stable(mainCnt) && presc == 12'h000)
        else $error("watchdog counted in stop");
    a_illegal_stop: assert property (state == WDOPT_RUN && stopReq && !stopOk |=> illegalStopRst && !stopMode)
        else $error("stop not refused");
    a_short_recover: assert property (s_wake_short |=> recCnt == WDOPT_SHORT_REC_CYC ##32 stopExit)
        else $error("short recovery length wrong");
    a_long_recover: assert property (s_wake_pin |=> recCnt == WDOPT_LONG_REC_CYC)
        else $error("reset pin wake not long");
    a_monitor_hold: assert property (monBlank || monIrqHold |-> !tick && !overflow)
        else $error("watchdog ran in monitor mode");

endmodule

// [test/wdopt_core_test.sv]
`timescale 1ns/1ps
module wdopt_core_test
    import wdopt_pkg::*;
;
    logic        clk;
    logic        nrst;
    logic        porN;
    wdopt_bus_t  bus;
    logic [7:0]  rdata;
    logic [7:0]  resetVecLow;
    logic        vectorFetch;
    logic        stopReq;
    logic        wakeIrq;
    logic        wakeRstPin;
    logic        monitorEnter;
    logic        breakActive;
    logic        vtstIrqPin;
    logic        vtstRstPin;
    logic        rstPinOut;
    logic        rstPinOe;
    logic        wdtCause;
    logic        illegalStopRst;
    logic        stopMode;
    logic        stopExit;
    wdopt_opts_t opts;
    int          numErrors;
    int          checkCount;
    int          n;
    int          cw;
    logic [7:0]  v;

    // Strobe masks for the pulse task, in the order of its concatenation
    localparam logic [4:0] P_FETCH = 5'h10;
    localparam logic [4:0] P_STOP  = 5'h08;
    localparam logic [4:0] P_WAKE  = 5'h04;
    localparam logic [4:0] P_PIN   = 5'h02;
    localparam logic [4:0] P_MON   = 5'h01;

    wdopt_core u_dut (.clk(clk), .nrst(nrst), .porN(porN), .bus(bus), .rdata(rdata),
        .resetVecLow(resetVecLow), .vectorFetch(vectorFetch), .stopReq(stopReq), .wakeIrq(wakeIrq),
        .wakeRstPin(wakeRstPin), .monitorEnter(monitorEnter), .breakActive(breakActive),
        .vtstIrqPin(vtstIrqPin), .vtstRstPin(vtstRstPin), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
        .wdtCause(wdtCause), .illegalStopRst(illegalStopRst), .stopMode(stopMode),
        .stopExit(stopExit), .opts(opts));

    // 40 MHz crystal clock
    always #12.5 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic endSim();
        $display("checks %0d mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bus tasks leave one idle edge so a strobe is never assigned twice in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask

    // Count edges until the reset pin is pulled, bounded by lim
    task automatic waitOe(input int lim, output int cnt);
        cnt = 0;
        #1;
        while (rstPinOe !== 1'b1 && cnt < lim) begin
            @(posedge clk);
            #1 cnt++;
        end
    endtask

    task automatic waitExit(output int cnt);
        cnt = 0;
        #1;
        while (stopExit !== 1'b1 && cnt < 5000) begin
            @(posedge clk);
            #1 cnt++;
        end
    endtask

    // One-cycle strobe; a mask instead of a reference keeps the non-blocking drive legal
    task automatic pulse(input logic [4:0] m);
        {vectorFetch, stopReq, wakeIrq, wakeRstPin, monitorEnter} <= m;
        @(posedge clk);
        {vectorFetch, stopReq, wakeIrq, wakeRstPin, monitorEnter} <= 5'h00;
    endtask

    task automatic doNrst();
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask

    // Hang guard, sized well above the sum of all waits
    initial begin
        #2450000;
        numErrors++;
        endSim();
    end

    initial begin
        clk = 1'b0; nrst = 1'b0; porN = 1'b0; bus = '0; resetVecLow = 8'hA5;
        vectorFetch = 1'b0; stopReq = 1'b0; wakeIrq = 1'b0; wakeRstPin = 1'b0; monitorEnter = 1'b0;
        breakActive = 1'b0; vtstIrqPin = 1'b0; vtstRstPin = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        porN <= 1'b1;
        repeat (3) @(posedge clk);
        rd(WDOPT_OPT1_ADDR, v); check("opt1 reset", v, 8'h00);
        rd(WDOPT_OPT2_ADDR, v); check("opt2 reset", v, 8'h00);
        rd(WDOPT_SERVICE_ADDR, v); check("service read", v, 8'hA5);
        rd(16'h0040, v); check("unmapped read", v, 8'h00);
        check("opts reset", opts, 6'h00);
        // Default slow rate must not expire in a fast-rate span
        wr(WDOPT_SERVICE_ADDR, 8'h00);
        waitOe(9000, n); check("slow rate quiet", rstPinOe, 1'b0);
        $display("test reset and slow rate done");
        wr(WDOPT_OPT1_ADDR, 8'hEE);
        wr(WDOPT_OPT1_ADDR, 8'h11);
        wr(WDOPT_OPT2_ADDR, 8'h02);
        wr(WDOPT_OPT2_ADDR, 8'h01);
        rd(WDOPT_OPT1_ADDR, v); check("opt1 once", v, 8'hEE);
        rd(WDOPT_OPT2_ADDR, v); check("opt2 once", v, 8'h02);
        check("osc in stop", opts.oscInStop, 1'b1);
        check("serial src", opts.serialClkSel, 1'b0);
        check("mon in stop", opts.monInStop, 1'b1);
        check("mon rst dis", opts.monResetDisable, 1'b1);
        check("mon pwr dn", opts.monPowerDown, 1'b0);
        check("five volt", opts.supplyFiveVolt, 1'b1);
        $display("test option latches done");
        // Regular service keeps the fast watchdog from firing
        repeat (3) begin
            wr(WDOPT_SERVICE_ADDR, 8'h5A);
            waitOe(7000, n); check("serviced quiet", rstPinOe, 1'b0);
        end
        // Vector fetch right after service zeroes the kept low stages, so the count is exact
        wr(WDOPT_SERVICE_ADDR, 8'h00);
        pulse(P_FETCH);
        waitOe(9000, n); check("fast timeout", n, 8176);
        check("cause pulse start", wdtCause, 1'b1);
        check("pin drives low", rstPinOut, 1'b0);
        n = 0;
        cw = 0;
        while (rstPinOe === 1'b1 && n < 100) begin
            n++;
            cw += (wdtCause === 1'b1);
            @(posedge clk);
            #1;
        end
        check("reset pin cycles", n, 32);
        check("cause pulses", cw, 1);
        $display("test watchdog timeout done");
        // Short recovery, then reset-pin wake with long recovery
        wr(WDOPT_SERVICE_ADDR, 8'h00);
        pulse(P_STOP);
        #1 check("stop entered", stopMode, 1'b1);
        @(posedge clk);
        pulse(P_WAKE);
        waitExit(n); check("short recovery", n, 32);
        check("stop left", stopMode, 1'b0);
        wr(WDOPT_SERVICE_ADDR, 8'h00);
        pulse(P_STOP);
        repeat (2) @(posedge clk);
        pulse(P_PIN);
        waitExit(n); check("pin wake recovery", n, 4096);
        wr(WDOPT_SERVICE_ADDR, 8'h00);
        waitOe(20, n); check("no oe after stop", rstPinOe, 1'b0);
        $display("test stop recovery done");
        // Internal reset clears options but not the supply range latch
        doNrst();
        check("range kept", opts.supplyFiveVolt, 1'b1);
        pulse(P_STOP);
        #1 check("illegal stop", illegalStopRst, 1'b1);
        check("no stop", stopMode, 1'b0);
        @(posedge clk);
        wr(WDOPT_OPT1_ADDR, 8'h81);
        check("range rewrite", opts.supplyFiveVolt, 1'b1);
        waitOe(9000, n); check("disabled quiet", rstPinOe, 1'b0);
        $display("test disable and range done");
        // Break with test voltage on the reset pin, then monitor hold by the IRQ pin
        doNrst();
        wr(WDOPT_OPT1_ADDR, 8'h80);
        breakActive <= 1'b1;
        vtstRstPin <= 1'b1;
        repeat (4) @(posedge clk);
        waitOe(9000, n); check("break quiet", rstPinOe, 1'b0);
        vtstIrqPin <= 1'b1;
        repeat (4) @(posedge clk);
        pulse(P_MON);
        breakActive <= 1'b0;
        vtstRstPin <= 1'b0;
        waitOe(9000, n); check("monitor quiet", rstPinOe, 1'b0);
        vtstIrqPin <= 1'b0;
        repeat (4) @(posedge clk);
        wr(WDOPT_SERVICE_ADDR, 8'h00);
        waitOe(9000, n); check("monitor released", rstPinOe, 1'b1);
        $display("test break and monitor done");
        endSim();
    end
endmodule
